// ==== logic/psp_pkg.sv ====
// Package for the per-pin pad state block: sizes, register map, reset values,
// CPU state columns and pad status codes.
// Assumes a 32-bit AXI4-Lite register bus and a single system clock.
package psp_pkg;
  localparam int NUM_PINS = 8;
  localparam int COL_W = 3;
  localparam int CODE_W = 4;

  // Register byte offsets
  localparam logic [7:0] CTRL_OFS = 8'h00;
  localparam logic [7:0] STATUS_OFS = 8'h04;
  localparam logic [7:0] PULLUP_SEL_OFS = 8'h08;
  localparam logic [7:0] PAD_IN_OFS = 8'h0c;
  localparam logic [7:0] PIN_MAP_OFS = 8'h10;

  // Control register fields
  localparam int CTRL_LEVEL_BIT = 0;
  localparam int CTRL_HOLD_BIT = 1;

  // Reset values
  localparam logic [NUM_PINS-1:0] PULLUP_SEL_RST = 8'hff;
  localparam logic [31:0] PIN_MAP_RST = 32'h0000_0000;

  localparam logic [1:0] RESP_OKAY = 2'b00;
  localparam logic [1:0] RESP_SLVERR = 2'b10;

  // Power mode reported by the power controller
  typedef enum logic [1:0] {
    PM_RUN = 2'b00,
    PM_STANDBY = 2'b01,
    PM_DEEP = 2'b10
  } psp_pmode_t;

  // CPU state columns
  typedef enum logic [COL_W-1:0] {
    COL_POR_RST = 3'b000,
    COL_EXT_RST = 3'b001,
    COL_RUN = 3'b010,
    COL_STBY_LO = 3'b011,
    COL_STBY_HI = 3'b100,
    COL_DEEP_LO = 3'b101,
    COL_DEEP_HI = 3'b110,
    COL_RUN_RET = 3'b111
  } psp_col_t;

  // Pad status codes
  typedef enum logic [CODE_W-1:0] {
    HIZ_INPUT_BLOCKED = 4'h0,
    HIZ_INPUT_OPEN = 4'h1,
    HIZ_PULL_PROGRAMMED = 4'h2,
    HIZ_INPUT_FOLLOWS_OSC = 4'h3,
    CRYSTAL_RUNNING = 4'h4,
    CRYSTAL_STOPPED_HIZ = 4'h5,
    USB_CTRL_DRIVEN = 4'h6,
    HOST_LINK_PAD_OFF = 4'h7,
    REG_DRIVEN_PULL_REG = 4'h8,
    REG_DRIVEN_NO_PULL = 4'h9,
    HELD_INPUT_LIVE = 4'ha,
    HELD_INPUT_BLOCKED = 4'hb,
    GPIO_COPIED_HELD = 4'hc,
    ANALOG_OFF = 4'hd
  } psp_code_t;
endpackage

// ==== logic/psp_top.sv ====
// Pad state logic for a bank of pins: picks each pin's drive, pull-up and
// input gating from its programmed status code for the present CPU state.
// Assumes reset and power mode inputs are synchronous to CLK_I.
//
// The AXI4-Lite register port and the address map are this design's own decisions.

// Operation
// - Power-on/low-supply reset and external-pin/system reset are separate columns.
// - Timer, RTC or stop mode uses one column per standby pin level value.
// - Deep standby modes likewise use one column per standby pin level value.
// - Run after deep standby is its own column; hold latch stays 1 until cleared.
// - hiz_input_blocked: output Hi-Z, pull-up off, input forced to 0.
// - hiz_input_open: output Hi-Z, pull-up off, input passes pin level.
// - hiz_pull_programmed: Hi-Z, input live, pull-up from pull-up select register.
// - hiz_input_follows_osc: Hi-Z, pull-up off, input passes only while oscillator runs.
// - crystal_running keeps oscillator on; crystal_stopped_hiz stops it, pin Hi-Z.
// - usb_ctrl_driven gives pad to USB; host_link_pad_off leaves it Hi-Z.
// - reg_driven_pull_reg: GPIO sets drive and pull-up, input live.
// - reg_driven_no_pull: GPIO sets drive, pull-up off, input live.
// - held_input_live: keep drive and pull-up from before state entry, input live.
// - held_input_blocked: keep drive and pull-up from before entry, input blocked.
// - gpio_copied_held: drive from GPIO copy taken at entry, input blocked.
// - Oscillator or analog function: output Hi-Z, pull-up off, input forced 0.
module psp_top (
  input wire logic CLK_I,
  input wire logic RST_I,
  input wire logic CE_I,
  input wire logic POR_RST_I,
  input wire logic EXT_RST_I,
  input wire logic [1:0] PMODE_I,
  input wire logic OSC_RUN_I,
  input wire logic [psp_pkg::NUM_PINS-1:0] PAD_I,
  input wire logic [psp_pkg::NUM_PINS-1:0] GPIO_DO_I,
  input wire logic [psp_pkg::NUM_PINS-1:0] GPIO_OE_I,
  input wire logic [psp_pkg::NUM_PINS-1:0] GPIO_PU_I,
  input wire logic [psp_pkg::NUM_PINS-1:0] USB_DO_I,
  input wire logic [psp_pkg::NUM_PINS-1:0] USB_OE_I,
  output logic [psp_pkg::NUM_PINS-1:0] PAD_DO_O,
  output logic [psp_pkg::NUM_PINS-1:0] PAD_OE_N_O,
  output logic [psp_pkg::NUM_PINS-1:0] PAD_PU_O,
  output logic [psp_pkg::NUM_PINS-1:0] PAD_IN_O,
  output logic [psp_pkg::NUM_PINS-1:0] OSC_EN_O,
  output logic [psp_pkg::COL_W-1:0] CPU_COL_O,
  input wire logic [7:0] AWADDR_I,
  input wire logic AWVALID_I,
  output logic AWREADY_O,
  input wire logic [31:0] WDATA_I,
  input wire logic [3:0] WSTRB_I,
  input wire logic WVALID_I,
  output logic WREADY_O,
  output logic [1:0] BRESP_O,
  output logic BVALID_O,
  input wire logic BREADY_I,
  input wire logic [7:0] ARADDR_I,
  input wire logic ARVALID_I,
  output logic ARREADY_O,
  output logic [31:0] RDATA_O,
  output logic [1:0] RRESP_O,
  output logic RVALID_O,
  input wire logic RREADY_I
);
  import psp_pkg::*;

  localparam int N = NUM_PINS;

  logic level_reg;
  logic hold_latch_reg;
  logic [N-1:0] pullup_sel_reg;
  logic [31:0] pin_map_reg [N];
  psp_col_t col_reg;
  // Pad values held since the last column change
  logic [N-1:0] hold_do_reg;
  logic [N-1:0] hold_oen_reg;
  logic [N-1:0] hold_pu_reg;
  // GPIO settings copied at the last column change
  logic [N-1:0] copy_do_reg;
  logic [N-1:0] copy_oen_reg;
  logic [N-1:0] copy_pu_reg;
  logic [N-1:0] do_next;
  logic [N-1:0] oen_next;
  logic [N-1:0] pu_next;
  logic [N-1:0] in_next;
  logic [N-1:0] osc_next;

  // Write address and data may arrive in either order
  logic [7:0] aw_addr_reg;
  logic [31:0] w_data_reg;
  logic [3:0] w_strb_reg;
  logic aw_full_reg;
  logic w_full_reg;
  logic awready_reg;
  logic wready_reg;
  logic bvalid_reg;
  logic arready_reg;
  logic rvalid_reg;
  logic [1:0] bresp_reg, rresp_reg;
  logic [31:0] rdata_reg;

  // CPU state column selection
  psp_pmode_t pmode;
  psp_col_t col_next;
  wire col_change = (col_next != col_reg);
  assign pmode = psp_pmode_t'(PMODE_I);
  assign col_next = POR_RST_I ? COL_POR_RST :
                    EXT_RST_I ? COL_EXT_RST :
                    (pmode == PM_STANDBY) ? (level_reg ? COL_STBY_HI : COL_STBY_LO) :
                    (pmode == PM_DEEP) ? (level_reg ? COL_DEEP_HI : COL_DEEP_LO) :
                    hold_latch_reg ? COL_RUN_RET : COL_RUN;

  // Held values come from the outputs as they stood just before entry
  wire [N-1:0] hsrc_do = col_change ? PAD_DO_O : hold_do_reg;
  wire [N-1:0] hsrc_oen = col_change ? PAD_OE_N_O : hold_oen_reg;
  wire [N-1:0] hsrc_pu = col_change ? PAD_PU_O : hold_pu_reg;
  wire [N-1:0] csrc_do = col_change ? GPIO_DO_I : copy_do_reg;
  wire [N-1:0] csrc_oen = col_change ? ~GPIO_OE_I : copy_oen_reg;
  wire [N-1:0] csrc_pu = col_change ? GPIO_PU_I : copy_pu_reg;

  // Pad evaluation: {do, oe_n, pu, in, osc_en}
  function automatic logic [4:0] pad_eval(
    input logic [CODE_W-1:0] code, input logic pin, input logic psel,
    input logic osc_run, input logic gdo, input logic goe, input logic gpu,
    input logic udo, input logic uoe, input logic hdo, input logic hoen,
    input logic hpu, input logic cdo, input logic coen, input logic cpu);
    logic [4:0] r;
    r = {1'b0, 1'b1, 1'b0, 1'b0, 1'b0};
    unique case (code)
      HIZ_INPUT_BLOCKED: r = {1'b0, 1'b1, 1'b0, 1'b0, 1'b0};
      HIZ_INPUT_OPEN: r = {1'b0, 1'b1, 1'b0, pin, 1'b0};
      HIZ_PULL_PROGRAMMED: r = {1'b0, 1'b1, psel, pin, 1'b0};
      HIZ_INPUT_FOLLOWS_OSC: r = {1'b0, 1'b1, 1'b0, pin & osc_run, 1'b0};
      CRYSTAL_RUNNING: r = {1'b0, 1'b1, 1'b0, 1'b0, 1'b1};
      CRYSTAL_STOPPED_HIZ: r = {1'b0, 1'b1, 1'b0, 1'b0, 1'b0};
      USB_CTRL_DRIVEN: r = {udo, ~uoe, 1'b0, pin, 1'b0};
      HOST_LINK_PAD_OFF: r = {1'b0, 1'b1, 1'b0, 1'b0, 1'b0};
      REG_DRIVEN_PULL_REG: r = {gdo, ~goe, gpu, pin, 1'b0};
      REG_DRIVEN_NO_PULL: r = {gdo, ~goe, 1'b0, pin, 1'b0};
      HELD_INPUT_LIVE: r = {hdo, hoen, hpu, pin, 1'b0};
      HELD_INPUT_BLOCKED: r = {hdo, hoen, hpu, 1'b0, 1'b0};
      GPIO_COPIED_HELD: r = {cdo, coen, cpu, 1'b0, 1'b0};
      ANALOG_OFF: r = {1'b0, 1'b1, 1'b0, 1'b0, 1'b0};
      default: r = {1'b0, 1'b1, 1'b0, 1'b0, 1'b0};
    endcase
    return r;
  endfunction

  genvar gi;
  generate
    for (gi = 0; gi < N; gi++) begin : g_pin
      wire [CODE_W-1:0] code = pin_map_reg[gi][col_next*CODE_W +: CODE_W];
      assign {do_next[gi], oen_next[gi], pu_next[gi], in_next[gi], osc_next[gi]} =
        pad_eval(code, PAD_I[gi], pullup_sel_reg[gi], OSC_RUN_I, GPIO_DO_I[gi],
                 GPIO_OE_I[gi], GPIO_PU_I[gi], USB_DO_I[gi], USB_OE_I[gi],
                 hsrc_do[gi], hsrc_oen[gi], hsrc_pu[gi],
                 csrc_do[gi], csrc_oen[gi], csrc_pu[gi]);
    end
  endgenerate

  always_ff @(posedge CLK_I) begin
    if (RST_I) begin
      col_reg <= COL_RUN;
      PAD_DO_O <= '0;
      PAD_OE_N_O <= '1;
      PAD_PU_O <= '0;
      PAD_IN_O <= '0;
      OSC_EN_O <= '0;
      hold_do_reg <= '0;
      hold_oen_reg <= '1;
      hold_pu_reg <= '0;
      copy_do_reg <= '0;
      copy_oen_reg <= '1;
      copy_pu_reg <= '0;
    end else if (CE_I) begin
      col_reg <= col_next;
      PAD_DO_O <= do_next;
      PAD_OE_N_O <= oen_next;
      PAD_PU_O <= pu_next;
      PAD_IN_O <= in_next;
      OSC_EN_O <= osc_next;
      hold_do_reg <= hsrc_do;
      hold_oen_reg <= hsrc_oen;
      hold_pu_reg <= hsrc_pu;
      copy_do_reg <= csrc_do;
      copy_oen_reg <= csrc_oen;
      copy_pu_reg <= csrc_pu;
    end
  end
  assign CPU_COL_O = col_reg;

  // AXI4-Lite write path
  wire aw_take = AWVALID_I & awready_reg;
  wire w_take = WVALID_I & wready_reg;
  wire aw_have = aw_full_reg | aw_take;
  wire w_have = w_full_reg | w_take;
  wire [7:0] wr_addr = aw_full_reg ? aw_addr_reg : AWADDR_I;
  wire [31:0] wr_data = w_full_reg ? w_data_reg : WDATA_I;
  wire [3:0] wr_strb = w_full_reg ? w_strb_reg : WSTRB_I;
  wire wr_fire = aw_have & w_have & ~bvalid_reg;
  wire wr_ctrl = (wr_addr == CTRL_OFS);
  wire wr_psel = (wr_addr == PULLUP_SEL_OFS);
  wire wr_map = (wr_addr >= PIN_MAP_OFS) && (wr_addr < PIN_MAP_OFS + 8'(4 * N)) &&
                (wr_addr[1:0] == 2'b00);
  wire [2:0] wr_map_idx = 3'((wr_addr - PIN_MAP_OFS) >> 2);
  wire wr_ok = wr_ctrl | wr_psel | wr_map | (wr_addr == STATUS_OFS) | (wr_addr == PAD_IN_OFS);
  wire [31:0] wr_mask = {{8{wr_strb[3]}}, {8{wr_strb[2]}}, {8{wr_strb[1]}}, {8{wr_strb[0]}}};
  wire [31:0] map_merged = (pin_map_reg[wr_map_idx] & ~wr_mask) | (wr_data & wr_mask);
  wire hold_clr = wr_fire & wr_ctrl & wr_strb[0] & ~wr_data[CTRL_HOLD_BIT];

  always_ff @(posedge CLK_I) begin
    if (RST_I) begin
      aw_full_reg <= 1'b0;
      w_full_reg <= 1'b0;
      aw_addr_reg <= 8'h00;
      w_data_reg <= 32'h0000_0000;
      w_strb_reg <= 4'h0;
      awready_reg <= 1'b1;
      wready_reg <= 1'b1;
      bvalid_reg <= 1'b0;
      bresp_reg <= RESP_OKAY;
      level_reg <= 1'b0;
      hold_latch_reg <= 1'b0;
      pullup_sel_reg <= PULLUP_SEL_RST;
      for (int i = 0; i < N; i++) begin
        pin_map_reg[i] <= PIN_MAP_RST;
      end
    end else if (CE_I) begin
      if (aw_take && !wr_fire) begin
        aw_full_reg <= 1'b1;
        aw_addr_reg <= AWADDR_I;
        awready_reg <= 1'b0;
      end
      if (w_take && !wr_fire) begin
        w_full_reg <= 1'b1;
        w_data_reg <= WDATA_I;
        w_strb_reg <= WSTRB_I;
        wready_reg <= 1'b0;
      end
      if (wr_fire) begin
        aw_full_reg <= 1'b0;
        w_full_reg <= 1'b0;
        awready_reg <= 1'b0;
        wready_reg <= 1'b0;
        bvalid_reg <= 1'b1;
        bresp_reg <= wr_ok ? RESP_OKAY : RESP_SLVERR;
        if (wr_ctrl && wr_strb[0]) begin
          level_reg <= wr_data[CTRL_LEVEL_BIT];
        end
        if (wr_psel && wr_strb[0]) begin
          pullup_sel_reg <= wr_data[N-1:0];
        end
        if (wr_map) begin
          pin_map_reg[wr_map_idx] <= map_merged;
        end
      end
      if (bvalid_reg && BREADY_I) begin
        bvalid_reg <= 1'b0;
        awready_reg <= 1'b1;
        wready_reg <= 1'b1;
      end
      // Deep standby sets the hold latch; set wins over a software clear
      if (pmode == PM_DEEP) begin
        hold_latch_reg <= 1'b1;
      end else if (hold_clr) begin
        hold_latch_reg <= 1'b0;
      end
    end
  end

  // AXI4-Lite read path
  wire ar_take = ARVALID_I & arready_reg;
  wire rd_map = (ARADDR_I >= PIN_MAP_OFS) && (ARADDR_I < PIN_MAP_OFS + 8'(4 * N)) &&
                (ARADDR_I[1:0] == 2'b00);
  wire [2:0] rd_map_idx = 3'((ARADDR_I - PIN_MAP_OFS) >> 2);
  wire [31:0] ctrl_val = {30'h0, hold_latch_reg, level_reg};
  wire [31:0] status_val = {27'h0, OSC_RUN_I, hold_latch_reg, col_reg};
  wire rd_ok = rd_map | (ARADDR_I == CTRL_OFS) | (ARADDR_I == STATUS_OFS) |
               (ARADDR_I == PULLUP_SEL_OFS) | (ARADDR_I == PAD_IN_OFS);
  wire [31:0] rd_val = (ARADDR_I == CTRL_OFS) ? ctrl_val :
                       (ARADDR_I == STATUS_OFS) ? status_val :
                       (ARADDR_I == PULLUP_SEL_OFS) ? {24'h0, pullup_sel_reg} :
                       (ARADDR_I == PAD_IN_OFS) ? {24'h0, PAD_IN_O} :
                       rd_map ? pin_map_reg[rd_map_idx] : 32'h0000_0000;

  always_ff @(posedge CLK_I) begin
    if (RST_I) begin
      arready_reg <= 1'b1;
      rvalid_reg <= 1'b0;
      rdata_reg <= 32'h0000_0000;
      rresp_reg <= RESP_OKAY;
    end else if (CE_I) begin
      if (ar_take) begin
        arready_reg <= 1'b0;
        rvalid_reg <= 1'b1;
        rdata_reg <= rd_val;
        rresp_reg <= rd_ok ? RESP_OKAY : RESP_SLVERR;
      end else if (rvalid_reg && RREADY_I) begin
        rvalid_reg <= 1'b0;
        arready_reg <= 1'b1;
      end
    end
  end

  assign AWREADY_O = awready_reg;
  assign WREADY_O = wready_reg;
  assign BVALID_O = bvalid_reg;
  assign BRESP_O = bresp_reg;
  assign ARREADY_O = arready_reg;
  assign RVALID_O = rvalid_reg;
  assign RDATA_O = rdata_reg;
  assign RRESP_O = rresp_reg;
endmodule

// ==== dv/psp_board.sv ====
// Board model for the pins of the pad state block.
// Assumes one clock; undriven, unpulled pins see a level that flips every cycle.
module psp_board (
  input wire logic clk_i,
  input wire logic [7:0] do_i,
  input wire logic [7:0] oe_n_i,
  input wire logic [7:0] pu_i,
  output logic [7:0] pad_o
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [7:0] ext_reg = 8'h5a;
  always @(posedge clk_i) ext_reg <= ~ext_reg;
  // Driven pin follows the pad, else pull-up, else outside level
  assign pad_o = (~oe_n_i & do_i) | (oe_n_i & (pu_i | ext_reg));
endmodule

// ==== dv/psp_checker.sv ====
// Checker for psp_top: CPU state columns and register bus answers.
// Assumes binding to psp_top, one clock, reset synchronous active high.
module psp_checker (
  input wire logic CLK_I,
  input wire logic RST_I,
  input wire logic CE_I,
  input wire logic POR_RST_I,
  input wire logic EXT_RST_I,
  input wire logic [1:0] PMODE_I,
  input wire logic [psp_pkg::COL_W-1:0] CPU_COL_O,
  input wire logic AWVALID_I,
  input wire logic AWREADY_O,
  input wire logic WVALID_I,
  input wire logic WREADY_O,
  input wire logic BVALID_O,
  input wire logic ARVALID_I,
  input wire logic ARREADY_O,
  input wire logic RVALID_O,
  input wire logic RREADY_I
);
  default clocking cb @(posedge CLK_I); endclocking
  default disable iff (RST_I);
  wire nr = CE_I && !POR_RST_I && !EXT_RST_I;
  por_column_a: assert property (CE_I && POR_RST_I |=> CPU_COL_O == 3'h0)
    else $error("power-on column wrong");
  ext_column_a: assert property (CE_I && !POR_RST_I && EXT_RST_I |=> CPU_COL_O == 3'h1)
    else $error("external reset column wrong");
  stby_column_a: assert property (nr && PMODE_I == 2'h1 |=> CPU_COL_O inside {3'h3, 3'h4})
    else $error("standby column wrong");
  deep_column_a: assert property (nr && PMODE_I == 2'h2 |=> CPU_COL_O inside {3'h5, 3'h6})
    else $error("deep standby column wrong");
  return_column_a: assert property (nr && PMODE_I == 2'h2 ##1 nr && PMODE_I == 2'h0
    |=> CPU_COL_O == 3'h7) else $error("return column wrong");
  read_take_a: assert property (CE_I && ARVALID_I && ARREADY_O |=> RVALID_O && !ARREADY_O)
    else $error("read answer late");
  write_take_a: assert property (CE_I && AWVALID_I && AWREADY_O && WVALID_I && WREADY_O
    |=> BVALID_O && !AWREADY_O && !WREADY_O) else $error("write answer late");
  read_hold_a: assert property (RVALID_O && !RREADY_I |=> RVALID_O)
    else $error("read answer dropped");
endmodule
bind psp_top psp_checker chk (.*);

// ==== dv/psp_top_bench.sv ====
// Self-checking bench for psp_top: registers, pad codes, held codes, columns.
// Assumes psp_checker is bound to the design and psp_board models the pins.
module psp_top_bench;
  timeunit 1ns;
  timeprecision 1ns;
  import psp_pkg::*;
  logic CLK_I, RST_I, CE_I, POR_RST_I, EXT_RST_I, OSC_RUN_I;
  logic AWVALID_I, AWREADY_O, WVALID_I, WREADY_O, BVALID_O, BREADY_I;
  logic ARVALID_I, ARREADY_O, RVALID_O, RREADY_I;
  logic [1:0] PMODE_I, BRESP_O, RRESP_O, r;
  logic [2:0] CPU_COL_O;
  logic [3:0] WSTRB_I;
  logic [7:0] PAD_I, GPIO_DO_I, GPIO_OE_I, GPIO_PU_I, USB_DO_I, USB_OE_I, ps, pv;
  logic [7:0] PAD_DO_O, PAD_OE_N_O, PAD_PU_O, PAD_IN_O, OSC_EN_O, AWADDR_I, ARADDR_I;
  logic [23:0] hold;
  logic [31:0] WDATA_I, RDATA_O, d;
  int failures, samples_checked, seed = 32'h7885;
  psp_top dut (.*);
  psp_board board (.clk_i(CLK_I), .do_i(PAD_DO_O), .oe_n_i(PAD_OE_N_O), .pu_i(PAD_PU_O),
    .pad_o(PAD_I));
  task automatic print_verdict;
    if (failures == 0 && samples_checked > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  task automatic cmp(input string nm, input logic [31:0] e, input logic [31:0] g);
    samples_checked++;
    if (g !== e) begin
      failures++;
      $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic tmo(input int n);
    if (n >= 50) begin
      failures++;
      print_verdict();
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] v, output logic [1:0] rs);
    int n;
    @(posedge CLK_I);
    {AWADDR_I, WDATA_I, WSTRB_I} <= {a, v, 4'hf};
    {AWVALID_I, WVALID_I, BREADY_I} <= 3'h7;
    n = 0;
    do begin
      @(posedge CLK_I);
      n++;
      if (AWREADY_O) AWVALID_I <= 1'b0;
      if (WREADY_O) WVALID_I <= 1'b0;
    end while (!BVALID_O && n < 50);
    rs = BRESP_O;
    BREADY_I <= 1'b0;
    tmo(n);
  endtask
  // Ready raised only after the answer shows, so the answer must wait
  task automatic rd(input logic [7:0] a, output logic [31:0] v, output logic [1:0] rs);
    int n;
    @(posedge CLK_I);
    ARADDR_I <= a;
    ARVALID_I <= 1'b1;
    n = 0;
    do begin
      @(posedge CLK_I);
      n++;
      if (ARREADY_O) ARVALID_I <= 1'b0;
      if (RVALID_O) RREADY_I <= 1'b1;
    end while (!(RVALID_O && RREADY_I) && n < 50);
    v = RDATA_O;
    rs = RRESP_O;
    RREADY_I <= 1'b0;
    tmo(n);
  endtask
  // Returns {oe_n, do, pu, in, osc_en}
  function automatic logic [4:0] pexp(logic [3:0] c, logic p, s, o, gd, ge, gp, ud, ue);
    case (c)
      4'h1: return {3'h4, p, 1'h0};
      4'h2: return {2'h2, s, p, 1'h0};
      4'h3: return {3'h4, p & o, 1'h0};
      4'h4: return 5'h11;
      4'h6: return {~ue, ud, 1'h0, p, 1'h0};
      4'h8: return {~ge, gd, gp, p, 1'h0};
      4'h9: return {~ge, gd, 1'h0, p, 1'h0};
      4'ha: return {3'h4, p, 1'h0};
      default: return 5'h10;
    endcase
  endfunction
  task automatic scan(input logic [3:0] c);
    logic [4:0] e [8];
    logic [4:0] m [8];
    logic [4:0] po;
    for (int k = 0; k < 12; k++) begin
      @(posedge CLK_I);
      {GPIO_DO_I, GPIO_OE_I, GPIO_PU_I, USB_DO_I} <= $random(seed);
      {USB_OE_I, OSC_RUN_I} <= 9'($random(seed));
      @(negedge CLK_I);
      for (int i = 0; i < 8; i++) begin
        po = {PAD_OE_N_O[i], PAD_DO_O[i], PAD_PU_O[i], PAD_IN_O[i], OSC_EN_O[i]} & m[i];
        if (k > 0) cmp("pad", 32'(e[i]), 32'(po));
        e[i] = pexp(c, PAD_I[i], ps[i], OSC_RUN_I, GPIO_DO_I[i], GPIO_OE_I[i], GPIO_PU_I[i],
          USB_DO_I[i], USB_OE_I[i]);
        m[i] = (c inside {[4'h6:4'h9]} && e[i][4]) ? 5'h17 : 5'h1f;
        e[i] = e[i] & m[i];
      end
    end
  endtask
  initial begin
    CLK_I = 1'b0;
    forever #5 CLK_I = ~CLK_I;
  end
  initial begin
    {RST_I, CE_I} = 2'h3;
    {POR_RST_I, EXT_RST_I, PMODE_I, OSC_RUN_I, BREADY_I, RREADY_I} = '0;
    {GPIO_DO_I, GPIO_OE_I, GPIO_PU_I, USB_DO_I, USB_OE_I, AWADDR_I, ARADDR_I} = '0;
    {AWVALID_I, WVALID_I, ARVALID_I, WDATA_I, WSTRB_I} = '0;
    repeat (4) @(posedge CLK_I);
    RST_I <= 1'b0;
    @(negedge CLK_I);
    cmp("col", 32'h2, 32'(CPU_COL_O));
    cmp("oe_n", 32'hff, 32'(PAD_OE_N_O));
    rd(PULLUP_SEL_OFS, d, r);
    cmp("pullup_sel", 32'(PULLUP_SEL_RST), d);
    rd(PIN_MAP_OFS, d, r);
    cmp("pin_map", PIN_MAP_RST, d);
    rd(8'h40, d, r);
    cmp("rresp", 32'(RESP_SLVERR), 32'(r));
    wr(8'h40, 32'h1, r);
    cmp("bresp", 32'(RESP_SLVERR), 32'(r));
    ps = 8'($random(seed));
    wr(PULLUP_SEL_OFS, 32'(ps), r);
    rd(PULLUP_SEL_OFS, d, r);
    cmp("pullup_sel", 32'(ps), d);
    for (int c = 0; c < 16; c++) begin
      for (int n = 0; n < 8; n++) wr(PIN_MAP_OFS + 8'(n * 4), {8{4'(c)}}, r);
      scan(4'(c));
    end
    // Run column drives from GPIO, standby column holds or copies it
    for (int n = 0; n < 8; n++) wr(PIN_MAP_OFS + 8'(n * 4), {16'h0, 4'ha + 4'(n % 3), 12'h800}, r);
    GPIO_OE_I <= 8'hff;
    {GPIO_DO_I, GPIO_PU_I} <= 16'($random(seed));
    repeat (2) @(posedge CLK_I);
    PMODE_I <= 2'h1;
    @(negedge CLK_I);
    hold = {PAD_OE_N_O, PAD_DO_O, PAD_PU_O};
    pv = PAD_I;
    @(posedge CLK_I);
    {GPIO_DO_I, GPIO_OE_I, GPIO_PU_I} <= 24'($random(seed));
    repeat (4) begin
      @(negedge CLK_I);
      cmp("held", 32'(hold), 32'({PAD_OE_N_O, PAD_DO_O, PAD_PU_O}));
      cmp("held_in", 32'(pv & 8'h49), 32'(PAD_IN_O));
      pv = PAD_I;
    end
    for (int j = 0; j < 6; j++) begin
      wr(CTRL_OFS, (j == 5) ? 32'h0 : {30'h0, 1'b1, 1'(j)}, r);
      PMODE_I <= (j < 2) ? 2'h1 : (j < 4) ? 2'h2 : 2'h0;
      @(posedge CLK_I);
      @(negedge CLK_I);
      cmp("col", (j < 4) ? 32'(3 + j) : (j == 4) ? 32'h7 : 32'h2, 32'(CPU_COL_O));
      if (j == 4) begin
        rd(CTRL_OFS, d, r);
        cmp("ctrl", 32'h2, d);
      end
    end
    rd(STATUS_OFS, d, r);
    cmp("status", {27'h0, OSC_RUN_I, 4'h2}, d);
    // Clock enable low freezes the column
    @(posedge CLK_I);
    CE_I <= 1'b0;
    PMODE_I <= 2'h1;
    repeat (2) @(posedge CLK_I);
    @(negedge CLK_I);
    cmp("col_frozen", 32'h2, 32'(CPU_COL_O));
    @(posedge CLK_I);
    {CE_I, PMODE_I} <= 3'h4;
    for (int k = 0; k < 2; k++) begin
      @(posedge CLK_I);
      {POR_RST_I, EXT_RST_I} <= (k == 0) ? 2'h1 : 2'h3;
      @(posedge CLK_I);
      @(negedge CLK_I);
      cmp("col", 32'(1 - k), 32'(CPU_COL_O));
    end
    print_verdict();
  end
endmodule
